// ### rtl/srr_pkg.sv
// Constants, types and register map of the service request status reporter.
// Assumes a classic Wishbone master with 32-bit data on the register side.
package srr_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_POST = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_POLL = 8'h0C;
   localparam logic [7:0] OFS_EVQ = 8'h10;
   localparam logic [7:0] OFS_COUNT = 8'h14;
   localparam logic [7:0] OFS_ENQ = 8'h18;
   localparam logic [7:0] OFS_MODE = 8'h1C;
   // Enable bit positions, in the order of the combined settings read
   localparam int EN_GLOBAL = 0;
   localparam int EN_CMD = 1;
   localparam int EN_EXE = 2;
   localparam int EN_INT = 3;
   localparam int EN_WARN = 4;
   localparam int EN_OPC = 5;
   localparam int EN_USER = 6;
   localparam int EN_PID = 7;
   localparam logic [7:0] EN_RESET = 8'hFF;
   localparam logic [4:0] MODE_RESET = 5'h00;
   // Post register fields
   localparam int POST_CODE_LSB = 0;
   localparam int POST_CLS_LSB = 16;
   // ****************************************
   // Status bytes and event codes
   // ****************************************
   localparam logic [7:0] SB_FATAL = 8'hA3;
   localparam logic [7:0] SB_POWER_ON = 8'h41;
   localparam logic [7:0] SB_CMD_ERR = 8'h21;
   localparam logic [7:0] SB_USER = 8'h43;
   localparam logic [7:0] SB_EXE_ERR = 8'h22;
   localparam logic [7:0] SB_INT_ERR = 8'h23;
   localparam logic [7:0] SB_EXE_WARN = 8'h25;
   localparam logic [7:0] SB_INT_WARN = 8'h26;
   localparam logic [7:0] SB_OP_DONE = 8'h02;
   localparam logic [7:0] SB_NONE = 8'h00;
   localparam logic [7:0] SB_RQ_BIT = 8'h40;
   localparam logic [7:0] SB_BUSY_BIT = 8'h10;
   localparam logic [1:0] PRIO_HIGH = 2'h1;
   localparam logic [1:0] PRIO_MID = 2'h2;
   localparam logic [1:0] PRIO_LOW = 2'h3;
   localparam logic [9:0] EV_POWER_ON = 10'h191;
   localparam logic [9:0] EV_SRQ_PEND = 10'h1CB;
   localparam int EV_TOTAL = 40;
   localparam int EV_LIFO_DEPTH = EV_TOTAL - 1;

   typedef enum logic [3:0] {
      CLS_NONE = 4'h0, CLS_FATAL = 4'h1, CLS_POWER_ON = 4'h2, CLS_CMD_ERR = 4'h3,
      CLS_USER = 4'h4, CLS_EXE_ERR = 4'h5, CLS_INT_ERR = 4'h6, CLS_EXE_WARN = 4'h7,
      CLS_INT_WARN = 4'h8, CLS_OP_DONE = 4'h9, CLS_PROBE_ID = 4'hA
   } srr_class_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } srr_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } srr_wb_rsp_t;

   typedef struct packed {
      logic [1:0] prio;
      logic [9:0] code;
   } srr_event_t;
endpackage

// ### rtl/srr_status_reporter.sv
// Service request status reporter: status byte path, event code store and
// request enables, reached over a classic Wishbone slave.
// Assumes one synchronous master on core_clk_i; events other than the power-on event are posted by writes.
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module srr_status_reporter #(
   parameter int LIFO_DEPTH = srr_pkg::EV_LIFO_DEPTH
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire srr_pkg::srr_wb_req_t wb_req_i,
   output srr_pkg::srr_wb_rsp_t wb_rsp_o,
   output logic srq_o,
   output logic halted_o
);
   import srr_pkg::*;

   localparam int CW = $clog2(LIFO_DEPTH + 1);

   // ****************************************
   // Class decoding
   // ****************************************
   function automatic logic [7:0] sb_value(input srr_class_t c, input logic rq,
                                           input logic busy);
      logic [7:0] v;
      v = SB_NONE;
      case (c)
         CLS_FATAL: v = SB_FATAL;
         CLS_POWER_ON: v = SB_POWER_ON;
         CLS_CMD_ERR: v = SB_CMD_ERR;
         CLS_USER, CLS_PROBE_ID: v = SB_USER;
         CLS_EXE_ERR: v = SB_EXE_ERR;
         CLS_INT_ERR: v = SB_INT_ERR;
         CLS_EXE_WARN: v = SB_EXE_WARN;
         CLS_INT_WARN: v = SB_INT_WARN;
         CLS_OP_DONE: v = SB_OP_DONE;
         default: v = SB_NONE;
      endcase
      // Power-on and user bytes carry a fixed request bit
      if (rq && c != CLS_POWER_ON && c != CLS_USER && c != CLS_PROBE_ID && c != CLS_NONE) begin
         v = v | SB_RQ_BIT;
      end
      if (busy) begin
         v = v | SB_BUSY_BIT;
      end
      return v;
   endfunction

   function automatic logic [1:0] cls_prio(input srr_class_t c);
      logic [1:0] p;
      case (c)
         CLS_FATAL, CLS_POWER_ON: p = PRIO_HIGH;
         CLS_NONE: p = PRIO_LOW;
         default: p = PRIO_MID;
      endcase
      return p;
   endfunction

   function automatic logic cls_enabled(input srr_class_t c, input logic [7:0] en);
      logic e;
      case (c)
         CLS_FATAL, CLS_POWER_ON: e = 1'b1;
         CLS_CMD_ERR: e = en[EN_GLOBAL] & en[EN_CMD];
         CLS_EXE_ERR: e = en[EN_GLOBAL] & en[EN_EXE];
         CLS_INT_ERR: e = en[EN_GLOBAL] & en[EN_INT];
         CLS_EXE_WARN: e = en[EN_GLOBAL] & en[EN_WARN];
         CLS_INT_WARN: e = en[EN_GLOBAL];
         CLS_OP_DONE: e = en[EN_GLOBAL] & en[EN_OPC];
         CLS_USER: e = en[EN_GLOBAL] & en[EN_USER];
         CLS_PROBE_ID: e = en[EN_GLOBAL] & en[EN_PID];
         default: e = 1'b0;
      endcase
      return e;
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************
   srr_wb_rsp_t rsp_ff;
   logic [7:0] en_ff;
   logic [4:0] mode_ff;
   logic [2:0] enq_sel_ff;
   logic po_done_ff;
   logic fatal_ff;
   logic srq_ff;
   logic polled_ff;
   logic [7:0] cur_sb_ff;
   logic [7:0] pend_sb_ff;
   logic [1:0] pend_sb_prio_ff;
   logic pend_sb_req_ff;
   logic pend_sb_v_ff;
   logic cur_ev_v_ff;
   logic [9:0] cur_ev_ff;
   logic pend_ev_v_ff;
   srr_event_t pend_ev_ff;
   srr_event_t lifo_ff [LIFO_DEPTH];
   logic [CW-1:0] lifo_cnt_ff;

   logic acc, wr, rd, wr_ok, post, poll, query, q_early, busy;
   logic new_ev, ev_in, sb_in, fatal_new, new_req;
   srr_class_t new_cls;
   logic [9:0] new_code;
   logic [1:0] new_prio;
   logic [7:0] new_sb;

   // Accesses wait until the power-on event has been posted
   assign acc = wb_req_i.cyc & wb_req_i.stb & ~rsp_ff.ack & po_done_ff;
   assign wr = acc & wb_req_i.we;
   assign rd = acc & ~wb_req_i.we;
   assign wr_ok = wr & ~fatal_ff;
   assign post = wr_ok & (wb_req_i.adr == OFS_POST) & (&wb_req_i.sel[2:0]);
   assign poll = rd & (wb_req_i.adr == OFS_POLL);
   assign query = rd & ~fatal_ff & (wb_req_i.adr == OFS_EVQ);
   assign q_early = srq_ff & ~polled_ff;
   assign busy = |mode_ff;

   assign new_ev = post | ~po_done_ff;
   assign new_cls = po_done_ff ? srr_class_t'(wb_req_i.dat[POST_CLS_LSB +: 4]) : CLS_POWER_ON;
   assign new_code = po_done_ff ? wb_req_i.dat[POST_CODE_LSB +: 10] : EV_POWER_ON;
   assign new_prio = cls_prio(new_cls);
   assign new_sb = sb_value(new_cls, en_ff[EN_GLOBAL], busy);
   assign new_req = cls_enabled(new_cls, en_ff);
   assign fatal_new = new_ev & ~fatal_ff & (new_cls == CLS_FATAL);
   assign sb_in = new_ev & ~fatal_ff & (new_cls != CLS_NONE) & ~fatal_new;
   // Masked classes still record their code
   assign ev_in = sb_in;

   // ****************************************
   // Software settings
   // ****************************************
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         en_ff <= EN_RESET;
         mode_ff <= MODE_RESET;
         enq_sel_ff <= 3'h0;
      end else if (wr_ok && wb_req_i.sel[0]) begin
         if (wb_req_i.adr == OFS_ENABLE) begin
            en_ff <= wb_req_i.dat[7:0];
         end
         if (wb_req_i.adr == OFS_MODE) begin
            mode_ff <= wb_req_i.dat[4:0];
         end
         if (wb_req_i.adr == OFS_ENQ) begin
            enq_sel_ff <= wb_req_i.dat[2:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         po_done_ff <= 1'b0;
         polled_ff <= 1'b0;
      end else begin
         po_done_ff <= 1'b1;
         if (poll) begin
            polled_ff <= 1'b1;
         end else if (query) begin
            polled_ff <= 1'b0;
         end
      end
   end

   // ****************************************
   // Status byte path
   // ****************************************
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cur_sb_ff <= SB_NONE;
         srq_ff <= 1'b0;
         fatal_ff <= 1'b0;
         pend_sb_ff <= SB_NONE;
         pend_sb_prio_ff <= PRIO_LOW;
         pend_sb_req_ff <= 1'b0;
         pend_sb_v_ff <= 1'b0;
      end else if (fatal_new) begin
         // Straight to the interface, request regardless of enables
         cur_sb_ff <= sb_value(CLS_FATAL, en_ff[EN_GLOBAL], busy);
         srq_ff <= 1'b1;
         fatal_ff <= 1'b1;
         pend_sb_v_ff <= 1'b0;
      end else if (sb_in) begin
         if (!srq_ff) begin
            cur_sb_ff <= new_sb;
            srq_ff <= new_req;
         end else if (!pend_sb_v_ff || new_prio < pend_sb_prio_ff) begin
            pend_sb_ff <= new_sb;
            pend_sb_prio_ff <= new_prio;
            pend_sb_req_ff <= new_req;
            pend_sb_v_ff <= 1'b1;
         end
      end else if (poll) begin
         srq_ff <= pend_sb_v_ff & pend_sb_req_ff & ~fatal_ff;
         if (pend_sb_v_ff && !fatal_ff) begin
            cur_sb_ff <= pend_sb_ff;
         end
         pend_sb_v_ff <= 1'b0;
      end
   end

   // ****************************************
   // Event code path
   // ****************************************
   logic push, pop;
   srr_event_t push_ev, new_event;
   assign new_event = '{prio: new_prio, code: new_code};

   always_comb begin
      push = 1'b0;
      pop = 1'b0;
      push_ev = new_event;
      if (ev_in) begin
         if (!en_ff[EN_GLOBAL]) begin
            push = 1'b1;
         end else if (cur_ev_v_ff && pend_ev_v_ff) begin
            push = 1'b1;
            if (new_prio < pend_ev_ff.prio) begin
               push_ev = pend_ev_ff;
            end
         end
      end else if ((query && !q_early) || (poll && polled_ff && !fatal_ff)) begin
         pop = (lifo_cnt_ff != '0);
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cur_ev_v_ff <= 1'b0;
         cur_ev_ff <= 10'h000;
         pend_ev_v_ff <= 1'b0;
         pend_ev_ff <= '0;
      end else if (ev_in && en_ff[EN_GLOBAL]) begin
         if (!cur_ev_v_ff) begin
            cur_ev_v_ff <= 1'b1;
            cur_ev_ff <= new_code;
         end else if (!pend_ev_v_ff || new_prio < pend_ev_ff.prio) begin
            pend_ev_v_ff <= 1'b1;
            pend_ev_ff <= new_event;
         end
      end else if (query && !q_early) begin
         if (pend_ev_v_ff) begin
            cur_ev_v_ff <= 1'b1;
            cur_ev_ff <= pend_ev_ff.code;
            pend_ev_v_ff <= pop;
            pend_ev_ff <= lifo_ff[0];
         end else begin
            cur_ev_v_ff <= pop;
            cur_ev_ff <= lifo_ff[0].code;
         end
      end else if (poll && polled_ff && !fatal_ff) begin
         // Second poll: the pending code belongs to a lost status byte
         pend_ev_v_ff <= pop;
         pend_ev_ff <= lifo_ff[0];
      end
   end

   // Newest entry at index 0; the oldest falls off the far end
   genvar gi;
   generate
      for (gi = 0; gi < LIFO_DEPTH; gi++) begin : g_lifo
         always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               lifo_ff[gi] <= '0;
            end else if (push) begin
               lifo_ff[gi] <= (gi == 0) ? push_ev : lifo_ff[(gi == 0) ? 0 : gi - 1];
            end else if (pop) begin
               lifo_ff[gi] <= (gi == LIFO_DEPTH - 1) ? '0 : lifo_ff[(gi == LIFO_DEPTH - 1) ? gi : gi + 1];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lifo_cnt_ff <= '0;
      end else if (push && lifo_cnt_ff != CW'(LIFO_DEPTH)) begin
         lifo_cnt_ff <= lifo_cnt_ff + CW'(1);
      end else if (pop) begin
         lifo_cnt_ff <= lifo_cnt_ff - CW'(1);
      end
   end

   // ****************************************
   // Read data and answer
   // ****************************************
   logic [31:0] rd_data;
   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_req_i.adr)
         OFS_ENABLE: rd_data = {24'h00_0000, en_ff};
         OFS_STATUS: rd_data = {8'h00, pend_sb_ff, 5'h00, pend_sb_v_ff, fatal_ff, srq_ff,
                                cur_sb_ff};
         OFS_POLL: rd_data = {24'h00_0000, cur_sb_ff};
         OFS_EVQ: begin
            if (q_early) begin
               rd_data = {22'h00_0000, EV_SRQ_PEND};
            end else if (cur_ev_v_ff) begin
               rd_data = {22'h00_0000, cur_ev_ff};
            end
         end
         OFS_COUNT: rd_data = 32'(lifo_cnt_ff) + 32'(cur_ev_v_ff) + 32'(pend_ev_v_ff);
         OFS_ENQ: rd_data = {21'h00_0000, enq_sel_ff, 7'h00, en_ff[enq_sel_ff]};
         OFS_MODE: rd_data = {27'h000_0000, mode_ff};
         default: rd_data = 32'h0000_0000;
      endcase
      if (fatal_ff && wb_req_i.adr != OFS_POLL) begin
         rd_data = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.ack <= acc;
         if (rd) begin
            rsp_ff.dat <= rd_data;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         srq_o <= 1'b0;
         halted_o <= 1'b0;
      end else begin
         srq_o <= srq_ff;
         halted_o <= fatal_ff;
      end
   end
   assign wb_rsp_o = rsp_ff;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_poll_clean;
      poll && !pend_sb_v_ff;
   endsequence
   sequence s_early_query;
      query && q_early;
   endsequence
   sequence s_answer_459;
      rsp_ff.ack && rsp_ff.dat == {22'h00_0000, EV_SRQ_PEND} ##1 !rsp_ff.ack;
   endsequence

   chk_poll_clears_srq: assert property (s_poll_clean |=> !srq_ff ##1 !srq_o)
      else $error("poll left request asserted");
   chk_poll_returns_byte: assert property (poll |=> rsp_ff.ack
      && rsp_ff.dat[7:0] == $past(cur_sb_ff)) else $error("poll answer is not the status byte");
   chk_fatal_direct: assert property (fatal_new |=> fatal_ff && srq_ff
      && (cur_sb_ff & 8'hAF) == SB_FATAL) else $error("fatal byte not placed at interface");
   chk_fatal_frozen: assert property (fatal_ff && wr |=> $stable(en_ff)
      && $stable(mode_ff)) else $error("write acted after fatal halt");
   // With global enable off, bit 6 may only stand as the fixed bit of the power-on and user bytes
   chk_rbit_gate: assert property (sb_in && !srq_ff && !en_ff[EN_GLOBAL] |=>
      !cur_sb_ff[6] || (cur_sb_ff[7:5] == 3'h2 && cur_sb_ff[0]))
      else $error("request bit set with global enable off");
   chk_busy_bit: assert property (sb_in && !srq_ff |=> cur_sb_ff[4] == $past(busy))
      else $error("busy bit does not follow acquisition mode");
   chk_lifo_bound: assert property (lifo_cnt_ff <= CW'(LIFO_DEPTH))
      else $error("event store count beyond depth");
   chk_bypass_store: assert property (ev_in && !en_ff[EN_GLOBAL]
      && lifo_cnt_ff < CW'(LIFO_DEPTH) |=> lifo_cnt_ff == $past(lifo_cnt_ff) + CW'(1)
      && lifo_ff[0].code == $past(new_code)) else $error("event with global off not stored");
   chk_pend_replace: assert property (ev_in && en_ff[EN_GLOBAL] && cur_ev_v_ff
      && pend_ev_v_ff && new_prio < pend_ev_ff.prio |=> pend_ev_ff.code == $past(new_code)
      && lifo_ff[0].code == $past(pend_ev_ff.code))
      else $error("higher priority code did not displace pending");
   chk_double_poll: assert property (poll && polled_ff && !fatal_ff
      && lifo_cnt_ff == '0 |=> !pend_ev_v_ff)
      else $error("pending code kept after second poll");
   chk_early_query: assert property (s_early_query |=> s_answer_459)
      else $error("early query did not return request-pending code");
endmodule // srr_status_reporter

// ### sim/srr_ctrl_model.sv
// Controller model: classic Wishbone master standing in for the bus controller.
// Assumes each call starts just after a rising edge of core_clk_i.
`timescale 1ns/10ps
module srr_ctrl_model (
   input wire logic core_clk_i,
   input wire srr_pkg::srr_wb_rsp_t wb_rsp_i,
   output srr_pkg::srr_wb_req_t wb_req_o
);
   import srr_pkg::*;

   // ****************************************
   // Bus cycle
   // ****************************************
   initial wb_req_o = '0;

   // Released lines show the inverse of the last value, so nothing stale can pass
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rdat);
      // No cycle limit of its own: the bench watchdog ends a hung wait
      wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
      do begin
         @(posedge core_clk_i);
      end while (wb_rsp_i.ack !== 1'b1);
      rdat = wb_rsp_i.dat;
      wb_req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~wd};
      @(posedge core_clk_i);
   endtask
endmodule // srr_ctrl_model

// ### sim/srr_status_reporter_test.sv
// Self-checking bench of the status reporter, controller model on its bus.
// Assumes srr_pkg and srr_ctrl_model are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin bad_count++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module srr_status_reporter_test;
   import srr_pkg::*;
   localparam int DEPTH = 4;
   logic core_clk_i;
   logic nrst_i;
   srr_wb_req_t wb_req;
   srr_wb_rsp_t wb_rsp;
   logic srq_o;
   logic halted_o;
   int bad_count = 0;
   int samples_checked = 0;
   logic [7:0] lfsr_st = 8'h37;
   logic [39:0] exp_q[$];
   logic [31:0] rd;
   logic [9:0] c1, c2, c3;
   logic [7:0] en;
   logic [3:0] cls_tab [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
   logic [7:0] sb_tab [7] = '{8'h61, 8'h43, 8'h62, 8'h63, 8'h65, 8'h66, 8'h42};

   srr_status_reporter #(.LIFO_DEPTH(DEPTH)) u_srr_status_reporter (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
      .srq_o(srq_o), .halted_o(halted_o));
   srr_ctrl_model u_srr_ctrl_model (
      .core_clk_i(core_clk_i), .wb_rsp_i(wb_rsp), .wb_req_o(wb_req));

   // ****************************************
   // Clock, scoreboard, watchdog
   // ****************************************
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   always @(posedge core_clk_i) begin
      if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
         if (exp_q.size() == 0) `CHK("read order", 1'b1, 1'b0)
         else begin
            `CHK($sformatf("reg %0h", exp_q[0][39:32]), exp_q[0][31:0], wb_rsp.dat)
            void'(exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (5000) @(posedge core_clk_i);
      bad_count++;
      tally_and_finish();
   end

   // ****************************************
   // Tasks
   // ****************************************
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic new_code(output logic [9:0] c);
      lfsr_st = lfsr(lfsr_st);
      c = {2'b01, lfsr_st};
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
      exp_q.push_back({adr, e});
      u_srr_ctrl_model.xfer(1'b0, adr, 32'h0, rd);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      u_srr_ctrl_model.xfer(1'b1, adr, d, rd);
   endtask

   task automatic post(input logic [3:0] cls, input logic [9:0] code);
      wr(OFS_POST, {12'h000, cls, 6'h00, code});
   endtask

   task automatic pin_chk(input logic sq, input logic hl);
      #1;
      `CHK("srq_o", sq, srq_o)
      `CHK("halted_o", hl, halted_o)
      @(posedge core_clk_i);
   endtask

   task automatic do_reset();
      nrst_i <= 1'b0;
      repeat (20) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
   endtask

   task automatic tally_and_finish();
      if (exp_q.size() != 0) bad_count++;
      $display("checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      nrst_i = 1'b0;
      @(posedge core_clk_i);
      do_reset();
      pin_chk(1'b1, 1'b0);
      rd_chk(OFS_ENABLE, 32'hFF);
      rd_chk(OFS_STATUS, 32'h141);
      rd_chk(OFS_COUNT, 32'h1);
      rd_chk(8'h20, 32'h0);
      rd_chk(OFS_EVQ, 32'd459);
      rd_chk(OFS_POLL, 32'h41);
      pin_chk(1'b0, 1'b0);
      rd_chk(OFS_EVQ, 32'd401);
      rd_chk(OFS_COUNT, 32'h0);
      for (int i = 0; i < 7; i++) begin
         new_code(c1);
         post(cls_tab[i], c1);
         pin_chk(1'b1, 1'b0);
         rd_chk(OFS_POLL, {24'h0, sb_tab[i]});
         rd_chk(OFS_EVQ, {22'h0, c1});
      end
      // A higher priority byte displaces the pending one
      new_code(c1);
      new_code(c2);
      post(4'h9, c1);
      post(4'h3, c2);
      post(4'h2, 10'd401);
      rd_chk(OFS_STATUS, 32'h0041_0542);
      rd_chk(OFS_COUNT, 32'h3);
      rd_chk(OFS_POLL, 32'h42);
      pin_chk(1'b1, 1'b0);
      rd_chk(OFS_EVQ, {22'h0, c1});
      rd_chk(OFS_POLL, 32'h41);
      rd_chk(OFS_EVQ, 32'd401);
      rd_chk(OFS_EVQ, {22'h0, c2});
      rd_chk(OFS_EVQ, 32'h0);
      // Two polls with no query between them
      new_code(c1);
      new_code(c2);
      new_code(c3);
      post(4'h5, c1);
      post(4'h7, c2);
      post(4'h3, c3);
      rd_chk(OFS_POLL, 32'h62);
      rd_chk(OFS_POLL, 32'h65);
      rd_chk(OFS_EVQ, {22'h0, c1});
      rd_chk(OFS_EVQ, {22'h0, c3});
      // Acquisition mode sets the busy bit
      new_code(c1);
      wr(OFS_MODE, 32'h1 << (lfsr_st % 8'd5));
      post(4'h5, c1);
      rd_chk(OFS_POLL, 32'h72);
      rd_chk(OFS_EVQ, {22'h0, c1});
      wr(OFS_MODE, 32'h0);
      // Global enable off: loaded quietly, power-on still requests
      wr(OFS_ENABLE, 32'hFE);
      post(4'h3, c1);
      pin_chk(1'b0, 1'b0);
      rd_chk(OFS_POLL, 32'h21);
      post(4'h2, 10'd401);
      pin_chk(1'b1, 1'b0);
      rd_chk(OFS_POLL, 32'h41);
      // Second reset in mid-run
      do_reset();
      pin_chk(1'b1, 1'b0);
      rd_chk(OFS_ENABLE, 32'hFF);
      rd_chk(OFS_POLL, 32'h41);
      rd_chk(OFS_EVQ, 32'd401);
      // Per-class enables and their single reads
      new_code(c1);
      en = {lfsr_st[7:2], 2'b01};
      wr(OFS_ENABLE, {24'h0, en});
      rd_chk(OFS_ENABLE, {24'h0, en});
      for (int i = 0; i < 8; i++) begin
         wr(OFS_ENQ, {29'h0, 3'(i)});
         rd_chk(OFS_ENQ, {21'h0, 3'(i), 7'h0, en[i]});
      end
      post(4'h3, c1);
      pin_chk(1'b0, 1'b0);
      rd_chk(OFS_COUNT, 32'h1);
      rd_chk(OFS_EVQ, {22'h0, c1});
      // Store overflow with prioritising bypassed
      wr(OFS_ENABLE, 32'hFE);
      for (int i = 0; i < DEPTH + 2; i++) begin
         new_code(c1);
         post(4'h5, c1);
      end
      rd_chk(OFS_COUNT, 32'(DEPTH));
      // Fatal: straight to the interface, then polls only
      post(4'h1, 10'h000);
      pin_chk(1'b1, 1'b1);
      rd_chk(OFS_POLL, 32'hA3);
      wr(OFS_ENABLE, 32'hFF);
      rd_chk(OFS_ENABLE, 32'h0);
      tally_and_finish();
   end
endmodule // srr_status_reporter_test
